//--- hw/ues_ahb_slave.sv
// AHB-Lite slave front end: captures address phase, issues register strobes that last the whole data phase.
`timescale 1ns/10ps
module ues_ahb_slave
	import ues_pkg::*;
(
	input wire logic clk, // Module clock.
	input wire logic rstn, // Synchronous reset, active low.
	input wire logic hsel, // Slave select.
	input wire logic [31:0] haddr, // Byte address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write when high.
	input wire logic hready, // Bus ready.
	input wire logic [31:0] hwdata, // Write data.
	output logic wr_stb, // One-cycle write strobe in the data phase.
	output logic rd_stb, // Read strobe, held for the whole data phase including its wait state.
	output logic [UES_ADDR_W-1:0] reg_addr, // Latched register address.
	output logic [7:0] wr_data // Write byte, valid with wr_stb.
);

	logic act_ff;
	logic write_ff;
	logic [UES_ADDR_W-1:0] addr_ff;

	// Address phase is taken whenever the bus is ready; held through a wait state.
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			act_ff <= 1'b0;
			write_ff <= 1'b0;
			addr_ff <= '0;
		end
		else if (hready)
		begin
			act_ff <= hsel && (htrans == UES_HTRANS_NONSEQ);
			write_ff <= hwrite;
			addr_ff <= haddr[UES_ADDR_W-1:0];
		end
	end

	assign wr_stb = act_ff && write_ff;
	assign rd_stb = act_ff && !write_ff;
	assign reg_addr = addr_ff;
	assign wr_data = hwdata[7:0];

endmodule

//--- hw/ues_core.sv
// Error flags, error enables, transaction status window and module control of the USB device.
//
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
module ues_core
	import ues_pkg::*;
(
	input wire logic clk, // Module clock, 250 MHz.
	input wire logic rstn, // Synchronous reset, active low.
	input wire logic hsel, // AHB-Lite slave select.
	input wire logic [31:0] haddr, // AHB-Lite address.
	input wire logic [1:0] htrans, // AHB-Lite transfer type.
	input wire logic hwrite, // AHB-Lite write.
	input wire logic [2:0] hsize, // AHB-Lite size, word only.
	input wire logic hready, // AHB-Lite bus ready.
	input wire logic [31:0] hwdata, // AHB-Lite write data.
	output logic [31:0] hrdata, // AHB-Lite read data.
	output logic hreadyout, // AHB-Lite slave ready.
	output logic hresp, // AHB-Lite response, always OKAY.
	input wire ues_err_t err_event, // One-cycle error detections from the serial engine.
	input wire logic txn_done, // Pulse: a descriptor was finished.
	input wire ues_status_t txn_status, // Status of the finished transaction.
	input wire logic setup_seen, // Pulse: a SETUP token was received.
	input wire logic [UES_BANK_EPS-1:0] bank_toggle, // Pulse per endpoint 5/6: flip bank bit.
	output logic engine_run, // Serial engine may process tokens.
	output logic engine_reset, // One-cycle reset of serial engine state.
	output logic resume_drive, // Drive resume signalling on the bus.
	output logic error_summary, // Error summary flag of interrupt flags.
	output logic token_done_flag, // Token-done flag of interrupt flags.
	output logic [UES_BANK_EPS-1:0] bank_bits, // Ping-pong bank bits of endpoints 5 and 6.
	output logic status_overflow // Pulse: status lost because FIFO full.
);

	logic wr_stb;
	logic rd_stb;
	logic [UES_ADDR_W-1:0] reg_addr;
	logic [7:0] wr_data;

	logic [7:0] err_flag_ff;
	logic [7:0] err_enb_ff;
	logic [7:0] ctl_ff;
	logic tokdone_ff;
	logic [UES_BANK_EPS-1:0] bank_ff;
	logic [31:0] rdata_ff;
	logic overflow_ff;
	logic engine_reset_ff;
	logic err_sum_ff;
	logic hreadyout_ff;
	logic read_request;

	logic [7:0] nxt_err_flag;
	logic [7:0] err_masked;
	logic tok_clear;
	logic fifo_pop;
	logic fifo_push;
	logic fifo_flush;
	logic fifo_not_empty;
	logic fifo_full;
	ues_status_t fifo_head;
	logic enable_rise;
	logic bank_clear;
	logic [7:0] err_evt_bits;

	ues_ahb_slave u_slave
	(
		.clk(clk),
		.rstn(rstn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hready(hready),
		.hwdata(hwdata),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb),
		.reg_addr(reg_addr),
		.wr_data(wr_data)
	);

	// A read address phase is taken while the bus is ready and the slave is selected.
	assign read_request = hready && hsel && (htrans == UES_HTRANS_NONSEQ) && !hwrite;

	// Reads get one wait state, because the read data register fills during the first data cycle.
	// Writes never wait, and the slave never signals an error.
	always_ff @(posedge clk)
	begin
		if (!rstn)
			hreadyout_ff <= 1'b1;
		else if (read_request)
			hreadyout_ff <= 1'b0;
		else
			hreadyout_ff <= 1'b1;
	end

	assign hreadyout = hreadyout_ff;
	assign hresp = 1'b0;
	assign hrdata = rdata_ff;

	// Error flags: events set, write-one clears, and a set in the same cycle wins.
	assign err_evt_bits = err_event & UES_ERROR_INTERRUPT_ENABLE_MASK;
	always_comb
	begin
		nxt_err_flag = err_flag_ff;
		if (wr_stb && reg_addr == UES_ADDR_ERRFLAG)
			nxt_err_flag = nxt_err_flag & ~wr_data;
		nxt_err_flag = nxt_err_flag | err_evt_bits;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			err_flag_ff <= UES_ERRFLAG_RST;
		else
			err_flag_ff <= nxt_err_flag;
	end

	// Error interrupt enables; bit 6 is not stored.
	always_ff @(posedge clk)
	begin
		if (!rstn)
			err_enb_ff <= UES_ERROR_INTERRUPT_ENABLE_RST;
		else if (wr_stb && reg_addr == UES_ADDR_ERROR_INTERRUPT_ENABLE)
			err_enb_ff <= wr_data & UES_ERROR_INTERRUPT_ENABLE_MASK;
	end

	// Each flag qualified by its own enable bit, then ORed into the summary.
	assign err_masked = err_flag_ff & err_enb_ff;

	always_ff @(posedge clk)
	begin
		if (!rstn)
			err_sum_ff <= 1'b0;
		else
			err_sum_ff <= |err_masked;
	end

	// Module control: hold bit set by SETUP, the rest written by software.
	assign enable_rise = wr_stb && reg_addr == UES_ADDR_CTRL && wr_data[UES_CTL_ENABLE]
		&& !ctl_ff[UES_CTL_ENABLE];
	assign bank_clear = wr_stb && reg_addr == UES_ADDR_CTRL && wr_data[UES_CTL_BANK_CLR];

	always_ff @(posedge clk)
	begin
		if (!rstn)
			ctl_ff <= UES_CTL_RST;
		else
		begin
			if (wr_stb && reg_addr == UES_ADDR_CTRL)
			begin
				ctl_ff[UES_CTL_SETUP_HOLD] <= wr_data[UES_CTL_SETUP_HOLD];
				ctl_ff[UES_CTL_RESUME] <= wr_data[UES_CTL_RESUME];
				ctl_ff[UES_CTL_ENABLE] <= wr_data[UES_CTL_ENABLE];
			end
			// SETUP arrival overrides a simultaneous software clear.
			if (setup_seen && ctl_ff[UES_CTL_ENABLE])
				ctl_ff[UES_CTL_SETUP_HOLD] <= 1'b1;
		end
	end

	// Bank bits: the engine flips them, bank clear or enable forces even.
	always_ff @(posedge clk)
	begin
		if (!rstn)
			bank_ff <= '0;
		else if (bank_clear || enable_rise)
			bank_ff <= '0;
		else if (ctl_ff[UES_CTL_ENABLE])
			bank_ff <= bank_ff ^ bank_toggle;
	end

	// Engine reset pulse on enabling; transceiver and regulator are not touched here.
	always_ff @(posedge clk)
	begin
		if (!rstn)
			engine_reset_ff <= 1'b0;
		else
			engine_reset_ff <= enable_rise;
	end

	// Status FIFO: completions push, clearing token-done pops the head.
	assign tok_clear = wr_stb && reg_addr == UES_ADDR_INTFLAG && wr_data[UES_INT_TOKDONE];
	assign fifo_pop = tok_clear && tokdone_ff;
	assign fifo_push = txn_done && ctl_ff[UES_CTL_ENABLE];
	assign fifo_flush = enable_rise;

	ues_status_fifo u_fifo
	(
		.clk(clk),
		.rstn(rstn),
		.flush(fifo_flush),
		.push(fifo_push),
		.push_data(txn_status),
		.pop(fifo_pop),
		.head(fifo_head),
		.not_empty(fifo_not_empty),
		.full(fifo_full)
	);

	// Token-done follows FIFO occupancy; a pop with more queued re-raises it next cycle.
	always_ff @(posedge clk)
	begin
		if (!rstn)
			tokdone_ff <= 1'b0;
		else if (fifo_pop)
			tokdone_ff <= 1'b0;
		else
			tokdone_ff <= fifo_not_empty;
	end

	// A completion that finds the FIFO full is lost; it is reported unless a pop falls in the same cycle.
	always_ff @(posedge clk)
	begin
		if (!rstn)
			overflow_ff <= 1'b0;
		else
			overflow_ff <= fifo_push && fifo_full && !fifo_pop;
	end

	// Read data registered in the data phase.
	always_ff @(posedge clk)
	begin
		if (!rstn)
			rdata_ff <= '0;
		else if (rd_stb)
		begin
			rdata_ff <= '0;
			unique case (reg_addr)
				UES_ADDR_INTFLAG:
					rdata_ff[7:0] <= {4'h0, tokdone_ff, 1'b0, err_sum_ff, 1'b0};
				UES_ADDR_ERRFLAG:
					rdata_ff[7:0] <= err_flag_ff;
				UES_ADDR_ERROR_INTERRUPT_ENABLE:
					rdata_ff[7:0] <= err_enb_ff;
				UES_ADDR_STATUS:
					// Valid only while token-done is set; otherwise reads zero.
					rdata_ff[7:0] <= tokdone_ff ? ues_status_byte(fifo_head) : 8'h00;
				UES_ADDR_CTRL:
					rdata_ff[7:0] <= ctl_ff;
				UES_ADDR_BANK:
					rdata_ff[7:0] <= {6'h00, bank_ff};
				default:
					rdata_ff <= '0;
			endcase
		end
	end

	// Outputs to the serial engine and interrupt logic.
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			engine_run <= 1'b0;
			resume_drive <= 1'b0;
		end
		else
		begin
			engine_run <= ctl_ff[UES_CTL_ENABLE] && !ctl_ff[UES_CTL_SETUP_HOLD];
			resume_drive <= ctl_ff[UES_CTL_RESUME];
		end
	end

	assign engine_reset = engine_reset_ff;
	assign error_summary = err_sum_ff;
	assign token_done_flag = tokdone_ff;
	assign bank_bits = bank_ff;
	assign status_overflow = overflow_ff;

endmodule

//--- hw/ues_pkg.sv
// Package with register map, field layouts and shared types of the USB error/status/control block.
package ues_pkg;

	// Register byte addresses on the AHB-Lite slave.
	localparam logic [7:0] UES_ADDR_INTFLAG = 8'h00;
	localparam logic [7:0] UES_ADDR_ERRFLAG = 8'h04;
	localparam logic [7:0] UES_ADDR_ERROR_INTERRUPT_ENABLE = 8'h08;
	localparam logic [7:0] UES_ADDR_STATUS = 8'h0C;
	localparam logic [7:0] UES_ADDR_CTRL = 8'h10;
	localparam logic [7:0] UES_ADDR_BANK = 8'h14;
	localparam int UES_ADDR_W = 8;

	// Interrupt flag register bit positions.
	localparam int UES_INT_ERROR = 1;
	localparam int UES_INT_TOKDONE = 3;

	// Error enable register: bit 6 is unimplemented.
	localparam logic [7:0] UES_ERROR_INTERRUPT_ENABLE_MASK = 8'hBF;
	localparam logic [7:0] UES_ERROR_INTERRUPT_ENABLE_RST = 8'h00;
	localparam logic [7:0] UES_ERRFLAG_RST = 8'h00;

	// Control register bit positions and reset value.
	localparam int UES_CTL_SETUP_HOLD = 5;
	localparam int UES_CTL_RESUME = 2;
	localparam int UES_CTL_BANK_CLR = 1;
	localparam int UES_CTL_ENABLE = 0;
	localparam logic [7:0] UES_CTL_RST = 8'h00;

	// Status FIFO geometry.
	localparam int UES_FIFO_DEPTH = 4;
	localparam int UES_PTR_W = 2;
	localparam logic [2:0] UES_CNT_FULL = 3'h4;
	localparam logic [2:0] UES_CNT_ONE = 3'h1;

	// Double-buffered endpoints with ping-pong bank bits.
	localparam int UES_BANK_EPS = 2;
	localparam logic [3:0] UES_EP_FIRST_PP = 4'h5;

	localparam logic [1:0] UES_HTRANS_NONSEQ = 2'h2;

	// One completed transaction as reported by the serial engine.
	typedef struct packed
	{
		logic [3:0] endpoint_number;
		logic is_in;
		logic is_odd;
	} ues_status_t;

	// Error events from the serial engine, one per flag bit position.
	typedef struct packed
	{
		logic bit_stuff;
		logic unused6;
		logic buffer;
		logic turnaround;
		logic partial_byte;
		logic data_checksum;
		logic token_checksum;
		logic packet_id;
	} ues_err_t;

	// Packs a status entry into the status window byte.
	function automatic logic [7:0] ues_status_byte(input ues_status_t s);
		ues_status_byte = {s.endpoint_number, s.is_in, s.is_odd, 2'h0};
	endfunction

endpackage

//--- hw/ues_status_fifo.sv
// Four-entry status FIFO that backs the transaction status window.
`timescale 1ns/10ps
module ues_status_fifo
	import ues_pkg::*;
(
	input wire logic clk, // Module clock.
	input wire logic rstn, // Synchronous reset, active low.
	input wire logic flush, // Drops every queued entry.
	input wire logic push, // Writes one entry when not full.
	input wire ues_status_t push_data, // Entry to write.
	input wire logic pop, // Retires the head entry.
	output ues_status_t head, // Oldest entry.
	output logic not_empty, // At least one entry queued.
	output logic full // No room for another entry.
);

	ues_status_t mem_ff [UES_FIFO_DEPTH];
	logic [UES_PTR_W-1:0] wr_ptr_ff;
	logic [UES_PTR_W-1:0] rd_ptr_ff;
	logic [2:0] count_ff;
	logic do_push;
	logic do_pop;

	assign do_pop = pop && (count_ff != 3'h0);
	assign do_push = push && (count_ff != UES_CNT_FULL);
	assign head = mem_ff[rd_ptr_ff];
	assign not_empty = (count_ff != 3'h0);
	assign full = (count_ff == UES_CNT_FULL);

	// Storage is not reset; the count alone says what is valid.
	always_ff @(posedge clk)
	begin
		if (do_push)
			mem_ff[wr_ptr_ff] <= push_data;
	end

	// Pointers and fill count.
	always_ff @(posedge clk)
	begin
		if (!rstn || flush)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end
		else
		begin
			if (do_push)
				wr_ptr_ff <= wr_ptr_ff + 2'h1;
			if (do_pop)
				rd_ptr_ff <= rd_ptr_ff + 2'h1;
			if (do_push && !do_pop)
				count_ff <= count_ff + UES_CNT_ONE;
			else if (do_pop && !do_push)
				count_ff <= count_ff - UES_CNT_ONE;
		end
	end

endmodule

//--- sim/ues_core_bench.sv
// Self-checking bench for the USB error, status and control core.
`timescale 1ns/10ps
module ues_core_bench;
	import ues_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp, txn_done, setup_seen, engine_run, engine_reset, resume_drive;
	logic error_summary, token_done_flag, status_overflow;
	logic [1:0] bank_toggle, bank_bits;
	ues_err_t err_event;
	ues_status_t txn_status;
	ues_status_t q[5];
	int errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int ovf = 0;
	ues_core ues_core_inst (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .err_event(err_event), .txn_done(txn_done),
		.txn_status(txn_status), .setup_seen(setup_seen), .bank_toggle(bank_toggle),
		.engine_run(engine_run), .engine_reset(engine_reset), .resume_drive(resume_drive),
		.error_summary(error_summary), .token_done_flag(token_done_flag),
		.bank_bits(bank_bits), .status_overflow(status_overflow));
	ues_engine_model ues_engine_model_inst (.clk(clk), .err_event(err_event),
		.txn_done(txn_done), .txn_status(txn_status), .setup_seen(setup_seen),
		.bank_toggle(bank_toggle));
	always #2 clk = ~clk;
	// Watchdog and count of dropped statuses.
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (status_overflow === 1'b1)
			ovf <= ovf + 1;
		if (cycles == 20000)
		begin
			errors = errors + 1;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task automatic chk_sig(input logic got, input logic exp);
		chk({31'h0000_0000, got}, {31'h0000_0000, exp});
	endtask
	// Address phase held until ready, then data phase held until ready; read data taken there.
	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
	begin
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= UES_HTRANS_NONSEQ;
		hwrite <= w;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
	end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(a, 1'b1, d);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
	begin
		ahb(a, 1'b0, 32'h0000_0000);
		chk(rd, exp);
	end
	endtask
	task automatic settle;
	begin
		repeat (3) @(posedge clk);
		#1;
	end
	endtask
	task automatic summarize;
	begin
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask
	initial
	begin
		q = '{'{4'h6, 1'b1, 1'b0}, '{4'h0, 1'b0, 1'b0}, '{4'h5, 1'b1, 1'b1},
			'{4'h3, 1'b0, 1'b1}, '{4'h2, 1'b1, 1'b1}};
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		rd_chk(UES_ADDR_ERROR_INTERRUPT_ENABLE, 32'h0000_0000);
		rd_chk(UES_ADDR_CTRL, 32'h0000_0000);
		wr(UES_ADDR_ERROR_INTERRUPT_ENABLE, 32'h0000_00FF);
		rd_chk(UES_ADDR_ERROR_INTERRUPT_ENABLE, 32'h0000_00BF);
		rd_chk(8'h40, 32'h0000_0000);
		$display("registers test ended");
		// Each source once enabled, once masked, then cleared by writing one.
		for (int b = 0; b < 8; b++)
		begin
			if (b == 6)
				continue;
			wr(UES_ADDR_ERROR_INTERRUPT_ENABLE, 32'h0000_0001 << b);
			ues_engine_model_inst.pulse_err(b);
			settle();
			chk_sig(error_summary, 1'b1);
			wr(UES_ADDR_ERROR_INTERRUPT_ENABLE, 32'h0000_0000);
			settle();
			chk_sig(error_summary, 1'b0);
			rd_chk(UES_ADDR_ERRFLAG, 32'h0000_0001 << b);
			wr(UES_ADDR_ERRFLAG, 32'h0000_0001 << b);
			rd_chk(UES_ADDR_ERRFLAG, 32'h0000_0000);
		end
		$display("error test ended");
		wr(UES_ADDR_CTRL, 32'h0000_0001);
		settle();
		chk_sig(engine_run, 1'b1);
		// Five completions, one every other cycle: four queue, the fifth is dropped.
		foreach (q[i]) ues_engine_model_inst.send_txn(q[i]);
		settle();
		chk(ovf, 32'h0000_0001);
		for (int i = 0; i < 4; i++)
		begin
			chk_sig(token_done_flag, 1'b1);
			rd_chk(UES_ADDR_STATUS, {24'h00_0000, q[i].endpoint_number, q[i].is_in,
				q[i].is_odd, 2'h0});
			wr(UES_ADDR_INTFLAG, 32'h0000_0008);
			settle();
		end
		chk_sig(token_done_flag, 1'b0);
		rd_chk(UES_ADDR_STATUS, 32'h0000_0000);
		$display("status test ended");
		ues_engine_model_inst.send_setup();
		settle();
		chk_sig(engine_run, 1'b0);
		rd_chk(UES_ADDR_CTRL, 32'h0000_0021);
		wr(UES_ADDR_CTRL, 32'h0000_0001);
		settle();
		chk_sig(engine_run, 1'b1);
		wr(UES_ADDR_CTRL, 32'h0000_0005);
		settle();
		chk_sig(resume_drive, 1'b1);
		repeat (50) @(posedge clk);
		wr(UES_ADDR_CTRL, 32'h0000_0001);
		settle();
		chk_sig(resume_drive, 1'b0);
		$display("control test ended");
		ues_engine_model_inst.send_toggle(2'h3);
		settle();
		chk({30'h0000_0000, bank_bits}, 32'h0000_0003);
		wr(UES_ADDR_CTRL, 32'h0000_0003);
		rd_chk(UES_ADDR_BANK, 32'h0000_0000);
		rd_chk(UES_ADDR_CTRL, 32'h0000_0001);
		ues_engine_model_inst.send_toggle(2'h1);
		wr(UES_ADDR_CTRL, 32'h0000_0000);
		wr(UES_ADDR_CTRL, 32'h0000_0001);
		rd_chk(UES_ADDR_BANK, 32'h0000_0000);
		$display("bank test ended");
		summarize();
	end
endmodule

//--- sim/ues_core_properties.sv
// Checker of bus answer, flag lifetimes and control outputs of the core.
`timescale 1ns/10ps
module ues_core_properties
	import ues_pkg::*;
(
	input wire logic clk, // Clock.
	input wire logic rstn, // Reset.
	input wire logic hsel, // Select.
	input wire logic [1:0] htrans, // Type.
	input wire logic hwrite, // Write.
	input wire logic hready, // Ready.
	input wire logic hreadyout, // Slave ready.
	input wire logic hresp, // Response.
	input wire logic txn_done, // Done.
	input wire logic setup_seen, // Setup.
	input wire logic [UES_BANK_EPS-1:0] bank_toggle, // Flips.
	input wire logic engine_run, // Run.
	input wire logic engine_reset, // Engine reset.
	input wire logic resume_drive, // Resume.
	input wire logic error_summary, // Summary.
	input wire logic token_done_flag, // Token done.
	input wire logic [UES_BANK_EPS-1:0] bank_bits, // Banks.
	input wire logic status_overflow // Overflow.
);
	logic [4:0] wr_hist_ff;
	logic wr_recent;
	// Only software writes may clear flags, start the engine, move resume or pulse engine reset, so recent writes are remembered.
	always_ff @(posedge clk)
	begin
		wr_hist_ff <= {wr_hist_ff[3:0], hsel && hready && hwrite && htrans == UES_HTRANS_NONSEQ};
	end
	assign wr_recent = |wr_hist_ff;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	a_bus_okay: assert property (!hresp) else $error("bus answer not okay");
	a_wait_single: assert property (!hreadyout |=> hreadyout)
		else $error("wait state longer than one cycle");
	a_setup_halts: assert property (setup_seen |-> ##[1:2] !engine_run)
		else $error("engine still runs after setup");
	a_run_rises: assert property ($rose(engine_run) |-> wr_recent)
		else $error("engine started without a write");
	a_summary_clear: assert property ($fell(error_summary) |-> wr_recent)
		else $error("error summary dropped by itself");
	a_token_clear: assert property ($fell(token_done_flag) |-> wr_recent)
		else $error("token done dropped by itself");
	a_token_sets: assert property (txn_done && !token_done_flag |-> ##[1:2] token_done_flag)
		else $error("token done not raised");
	a_resume_cause: assert property ($changed(resume_drive) |-> wr_recent)
		else $error("resume moved without a write");
	a_bank_cause: assert property ($changed(bank_bits) |-> wr_recent || $past(bank_toggle) != 0
		|| $past(bank_toggle, 2) != 0) else $error("bank bits moved without cause");
	a_reset_pulse: assert property (engine_reset |-> wr_recent ##1 !engine_reset)
		else $error("engine reset not a single pulse after a write");
	a_overflow_full: assert property (status_overflow |-> token_done_flag
		&& ($past(txn_done) || $past(txn_done, 2))) else $error("overflow without push");
endmodule
bind ues_core ues_core_properties ues_core_properties_inst (.clk, .rstn, .hsel, .htrans,
	.hwrite, .hready, .hreadyout, .hresp, .txn_done, .setup_seen, .bank_toggle, .engine_run,
	.engine_reset, .resume_drive, .error_summary, .token_done_flag, .bank_bits, .status_overflow);

//--- sim/ues_engine_model.sv
// Behavioural model of the serial engine feeding events into the core.
`timescale 1ns/10ps
module ues_engine_model
	import ues_pkg::*;
(
	input wire logic clk, // Clock.
	output ues_err_t err_event, // Error pulses.
	output logic txn_done, // Transaction done.
	output ues_status_t txn_status, // Its status.
	output logic setup_seen, // Setup token.
	output logic [UES_BANK_EPS-1:0] bank_toggle // Bank flips.
);
	// Events last one clock; status shows a scrambled value outside its pulse.
	initial
	begin
		err_event = '0;
		txn_done = 1'b0;
		txn_status = '1;
		setup_seen = 1'b0;
		bank_toggle = 2'h0;
	end
	task automatic pulse_err(input int b);
		logic [7:0] v;
	begin
		v = 8'h01 << b;
		@(posedge clk);
		err_event <= ues_err_t'(v);
		@(posedge clk);
		err_event <= '0;
	end
	endtask
	task automatic send_txn(input ues_status_t s);
	begin
		@(posedge clk);
		txn_done <= 1'b1;
		txn_status <= s;
		@(posedge clk);
		txn_done <= 1'b0;
		txn_status <= ~s;
	end
	endtask
	task automatic send_setup;
	begin
		@(posedge clk);
		setup_seen <= 1'b1;
		@(posedge clk);
		setup_seen <= 1'b0;
	end
	endtask
	task automatic send_toggle(input logic [1:0] t);
	begin
		@(posedge clk);
		bank_toggle <= t;
		@(posedge clk);
		bank_toggle <= 2'h0;
	end
	endtask
endmodule
